// ### rtl/mps_pkg.sv
// constants, register map and state codes of the module power sequencer
// assumes a 100 MHz core clock and a 32-bit apb register bus
package mps_pkg;
    localparam int CLK_MHZ          = 100;
    // power request low time that counts as a start-up event
    localparam int PWR_REQ_MIN_US   = 50;
    localparam int PWR_REQ_MIN_CYC  = PWR_REQ_MIN_US * CLK_MHZ;
    // abrupt reboot low time that counts as valid
    localparam int RST_MIN_US       = 10;
    localparam int RST_MIN_CYC      = RST_MIN_US * CLK_MHZ;
    // core reset hold after interface supply turns on
    localparam int BOOT_HOLD_NS     = 1000;
    localparam int BOOT_HOLD_CYC    = BOOT_HOLD_NS * CLK_MHZ / 1000;
    // spacing between pins leaving reset
    localparam int PIN_STEP_NS      = 200;
    localparam int PIN_STEP_CYC     = PIN_STEP_NS * CLK_MHZ / 1000;
    // safe under-voltage margin after abrupt reboot goes low
    localparam int UV_SAFE_MS       = 405;
    localparam int UV_SAFE_CYC      = UV_SAFE_MS * 1000 * CLK_MHZ;

    localparam int AW    = 8;
    localparam int CW    = 16;
    localparam int UW    = 26;
    localparam int NPINS = 4;
    localparam int NEV   = 4;

    localparam logic [AW-1:0] OFS_CTRL  = 8'h00;
    localparam logic [AW-1:0] OFS_CMD   = 8'h04;
    localparam logic [AW-1:0] OFS_STAT  = 8'h08;
    localparam logic [AW-1:0] OFS_ISTAT = 8'h0c;
    localparam logic [AW-1:0] OFS_IMASK = 8'h10;

    localparam int CTRL_GREET = 0;
    localparam int CTRL_GASP  = 1;
    localparam int CTRL_TEMP  = 2;
    localparam int CTRL_FAST  = 3;
    localparam logic [3:0] CTRL_RST  = 4'h0;
    localparam logic [3:0] IMASK_RST = 4'h0;

    localparam logic [7:0] CMD_NONE   = 8'h00;
    localparam logic [7:0] CMD_OFF    = 8'h01;
    localparam logic [7:0] CMD_FAST   = 8'h0a;
    localparam logic [7:0] CMD_REBOOT = 8'h10;

    localparam int EV_READY  = 0;
    localparam int EV_OFF    = 1;
    localparam int EV_REBOOT = 2;
    localparam int EV_TEMP   = 3;

    typedef enum logic [7:0] {
        S_OFF    = 8'h01,
        S_SLEEP  = 8'h02,
        S_BOOT   = 8'h04,
        S_PINCFG = 8'h08,
        S_GREET  = 8'h10,
        S_READY  = 8'h20,
        S_STORE  = 8'h40,
        S_DETACH = 8'h80
    } mps_state_t;
endpackage

// ### rtl/mps_power_seq.sv
// module power sequencer: switch-on, wake, switch-off and reboot control
// assumes pins arrive asynchronous, store/detach/gasp/temp/sleep come from same-clock logic
//
// Summary of operation
// - a valid low period on power request starts switch-on or wake-up
// - digital pins stay high impedance until interface supply is on
// - core and pins held in reset, then pins released one by one
// - optional greeting after init; ready only once all pins configured
// - graceful off command answers OK, stores settings, detaches
// - end of switch-off tri-states pins and drops all supplies
// - off state holds until a power request start-up event
// - abrupt reboot low 405 ms before supply loss makes shutdown safe
// - valid abrupt reboot pulse resets core at once, supply kept
// - command 10 or fast-off pin toggle: store then off, no detach
// - command 16: store, detach, then reboot
// - power request pulse while reboot held low is emergency shutdown
// - enabled last gasp: store then off, no detach
// - enabled temperature supervisor danger shuts the device down
// - interface supply low when off or asleep, high otherwise
`timescale 1ns/100ps
module mps_power_seq #(
    parameter logic [mps_pkg::CW-1:0] PWR_MIN_CYC = mps_pkg::CW'(mps_pkg::PWR_REQ_MIN_CYC),
    parameter logic [mps_pkg::UW-1:0] UV_CYC      = mps_pkg::UW'(mps_pkg::UV_SAFE_CYC)
) (
    input  wire  logic                     core_clk_in,
    input  wire  logic                     reset_n_in,
    input  wire  logic                     ce_in,
    input  wire  logic                     psel_in,
    input  wire  logic                     penable_in,
    input  wire  logic                     pwrite_in,
    input  wire  logic [mps_pkg::AW-1:0]   paddr_in,
    input  wire  logic [31:0]              pwdata_in,
    output logic       [31:0]              prdata_out,
    output logic                           pready_out,
    output logic                           pslverr_out,
    input  wire  logic                     power_request_n_in,
    input  wire  logic                     reboot_n_in,
    input  wire  logic                     fast_off_pin_in,
    input  wire  logic                     store_done_in,
    input  wire  logic                     detach_done_in,
    input  wire  logic                     last_gasp_sent_in,
    input  wire  logic                     temp_danger_in,
    input  wire  logic                     sleep_req_in,
    output logic                           vint_on_out,
    output logic                           pins_hiz_out,
    output logic                           core_reset_n_out,
    output logic       [mps_pkg::NPINS-1:0] pin_release_out,
    output logic                           greeting_out,
    output logic                           ok_resp_out,
    output logic                           store_req_out,
    output logic                           detach_req_out,
    output logic                           ready_out,
    output logic                           uv_safe_out,
    output logic                           irq_out
);
    import mps_pkg::*;

    function automatic logic [CW-1:0] sat_inc(input logic [CW-1:0] v);
        sat_inc = (&v) ? v : v + 16'h0001;
    endfunction

    // pin synchronisers {fast, reboot, power}
    logic [2:0] sy1_q, sy2_q;
    logic       fast_prev_q;
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sy1_q       <= 3'h3;
            sy2_q       <= 3'h3;
            fast_prev_q <= 1'b0;
        end else if (ce_in) begin
            sy1_q       <= {fast_off_pin_in, reboot_n_in, power_request_n_in};
            sy2_q       <= sy1_q;
            fast_prev_q <= sy2_q[2];
        end
    end

    mps_state_t         st_q, st_d;
    logic [CW-1:0]      cnt_q, cnt_d, pcnt_q, pcnt_d, rcnt_q, rcnt_d;
    logic [UW-1:0]      uv_q, uv_d;
    logic [NPINS-1:0]   pin_q, pin_d;
    logic               rb_q, rb_d, dt_q, dt_d;
    logic               vint_q, vint_d, hiz_q, crst_q, crst_d, greet_q, greet_d, ok_q, ok_d;
    logic               store_q, det_q, ready_q, uvs_q, uvs_d;
    logic [NEV-1:0]     ev;
    logic               take, active, pwr_evt, rst_evt;
    logic [3:0]         ctrl_q, ctrl_d, istat_q, istat_d, imask_q, imask_d;
    logic [7:0]         cmd_q, cmd_d;
    logic [31:0]        rdata_q, rdata_d;
    logic               prdy_q, prdy_d, perr_q, perr_d, irq_q, irq_d;

    // start-up event on valid low time
    // short pulses never reach the threshold
    assign pwr_evt = !sy2_q[0] && (pcnt_q == PWR_MIN_CYC - 16'h0001);
    assign rst_evt = !sy2_q[1] && (rcnt_q == CW'(RST_MIN_CYC - 1));
    assign active  = !(st_q == S_OFF || st_q == S_SLEEP);

    always_comb begin
        st_d    = st_q;
        cnt_d   = sat_inc(cnt_q);
        pin_d   = pin_q;
        rb_d    = rb_q;
        dt_d    = dt_q;
        ok_d    = 1'b0;
        greet_d = 1'b0;
        take    = 1'b0;
        ev      = '0;
        pcnt_d  = sy2_q[0] ? '0 : sat_inc(pcnt_q);
        rcnt_d  = sy2_q[1] ? '0 : sat_inc(rcnt_q);
        // margin flag after reboot held low
        uv_d    = sy2_q[1] ? '0 : ((uv_q == UV_CYC) ? uv_q : uv_q + 26'h1);
        uvs_d   = !sy2_q[1] && (uv_q == UV_CYC);
        if (active && pwr_evt && !sy2_q[1]) begin
            st_d = S_OFF;
        end else if (active && ctrl_q[CTRL_TEMP] && temp_danger_in) begin
            st_d        = S_OFF;
            ev[EV_TEMP] = 1'b1;
        end else if (active && rst_evt) begin
            st_d          = S_BOOT;
            ev[EV_REBOOT] = 1'b1;
        end else begin
            case (st_q)
                // off and sleep wait for power request
                S_OFF, S_SLEEP: begin
                    if (pwr_evt)
                        st_d = S_BOOT;
                end
                // hold core reset after supply up
                S_BOOT: begin
                    if (cnt_q == CW'(BOOT_HOLD_CYC - 1))
                        st_d = S_PINCFG;
                end
                S_PINCFG: begin
                    if (&pin_q) begin
                        st_d = ctrl_q[CTRL_GREET] ? S_GREET : S_READY;
                    end else if (cnt_q == CW'(PIN_STEP_CYC - 1)) begin
                        pin_d = {pin_q[NPINS-2:0], 1'b1};
                        cnt_d = '0;
                    end
                end
                S_GREET: begin
                    st_d    = S_READY;
                end
                S_READY: begin
                    if (cmd_q != CMD_NONE) begin
                        take = 1'b1;
                        case (cmd_q)
                            CMD_OFF: begin
                                ok_d = 1'b1;
                                rb_d = 1'b0;
                                dt_d = 1'b1;
                                st_d = S_STORE;
                            end
                            CMD_FAST: begin
                                rb_d = 1'b0;
                                dt_d = 1'b0;
                                st_d = S_STORE;
                            end
                            CMD_REBOOT: begin
                                rb_d = 1'b1;
                                dt_d = 1'b1;
                                st_d = S_STORE;
                            end
                            default: begin
                            end
                        endcase
                    end else if ((ctrl_q[CTRL_GASP] && last_gasp_sent_in) ||
                                 (ctrl_q[CTRL_FAST] && (sy2_q[2] != fast_prev_q))) begin
                        rb_d = 1'b0;
                        dt_d = 1'b0;
                        st_d = S_STORE;
                    end else if (sleep_req_in) begin
                        st_d = S_SLEEP;
                    end
                end
                S_STORE: begin
                    if (store_done_in)
                        st_d = dt_q ? S_DETACH : (rb_q ? S_BOOT : S_OFF);
                end
                S_DETACH: begin
                    if (detach_done_in)
                        st_d = rb_q ? S_BOOT : S_OFF;
                end
                default: st_d = S_OFF;
            endcase
        end
        if (st_d != st_q)
            cnt_d = '0;
        if (st_d == S_OFF || st_d == S_SLEEP || st_d == S_BOOT)
            pin_d = '0;
        ev[EV_READY] = (st_d == S_READY) && (st_q != S_READY);
        ev[EV_OFF]   = active && (st_d == S_OFF);
        greet_d      = (st_d == S_GREET);
        vint_d = !(st_d == S_OFF || st_d == S_SLEEP);
        crst_d = vint_d && (st_d != S_BOOT);
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_q    <= S_OFF;
            cnt_q   <= '0;
            pcnt_q  <= '0;
            rcnt_q  <= '0;
            uv_q    <= '0;
            uvs_q   <= 1'b0;
            pin_q   <= '0;
            rb_q    <= 1'b0;
            dt_q    <= 1'b0;
            vint_q  <= 1'b0;
            hiz_q   <= 1'b1;
            crst_q  <= 1'b0;
            greet_q <= 1'b0;
            ok_q    <= 1'b0;
            store_q <= 1'b0;
            det_q   <= 1'b0;
            ready_q <= 1'b0;
        end else if (ce_in) begin
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            pcnt_q  <= pcnt_d;
            rcnt_q  <= rcnt_d;
            uv_q    <= uv_d;
            uvs_q   <= uvs_d;
            pin_q   <= pin_d;
            rb_q    <= rb_d;
            dt_q    <= dt_d;
            vint_q  <= vint_d;
            // pins float whenever supply is off
            hiz_q   <= !vint_d;
            crst_q  <= crst_d;
            greet_q <= greet_d;
            ok_q    <= ok_d;
            store_q <= (st_d == S_STORE);
            det_q   <= (st_d == S_DETACH);
            ready_q <= (st_d == S_READY);
        end
    end

    // apb slave, answers in the second access cycle
    always_comb begin
        ctrl_d  = ctrl_q;
        cmd_d   = take ? CMD_NONE : cmd_q;
        imask_d = imask_q;
        istat_d = istat_q;
        rdata_d = rdata_q;
        perr_d  = 1'b0;
        prdy_d  = psel_in && penable_in && !prdy_q;
        if (prdy_d) begin
            case (paddr_in)
                OFS_CTRL:  rdata_d = {28'h0, ctrl_q};
                OFS_CMD:   rdata_d = {24'h0, cmd_q};
                OFS_STAT:  rdata_d = {22'h0, uvs_q, ready_q, st_q};
                OFS_ISTAT: rdata_d = {28'h0, istat_q};
                OFS_IMASK: rdata_d = {28'h0, imask_q};
                default: begin
                    rdata_d = '0;
                    perr_d  = 1'b1;
                end
            endcase
        end
        if (psel_in && penable_in && prdy_q && pwrite_in) begin
            case (paddr_in)
                OFS_CTRL:  ctrl_d  = pwdata_in[3:0];
                OFS_CMD:   cmd_d   = pwdata_in[7:0];
                OFS_ISTAT: istat_d = istat_q & ~pwdata_in[3:0];
                OFS_IMASK: imask_d = pwdata_in[3:0];
                default: begin
                end
            endcase
        end
        // new events win over a clear in the same cycle
        istat_d = istat_d | ev;
        irq_d   = |(istat_d & imask_d);
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_q  <= CTRL_RST;
            cmd_q   <= CMD_NONE;
            istat_q <= '0;
            imask_q <= IMASK_RST;
            rdata_q <= '0;
            prdy_q  <= 1'b0;
            perr_q  <= 1'b0;
            irq_q   <= 1'b0;
        end else if (ce_in) begin
            ctrl_q  <= ctrl_d;
            cmd_q   <= cmd_d;
            istat_q <= istat_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            prdy_q  <= prdy_d;
            perr_q  <= perr_d;
            irq_q   <= irq_d;
        end
    end

    assign prdata_out       = rdata_q;
    assign pready_out       = prdy_q;
    assign pslverr_out      = perr_q;
    assign vint_on_out      = vint_q;
    assign pins_hiz_out     = hiz_q;
    assign core_reset_n_out = crst_q;
    assign pin_release_out  = pin_q;
    assign greeting_out     = greet_q;
    assign ok_resp_out      = ok_q;
    assign store_req_out    = store_q;
    assign detach_req_out   = det_q;
    assign ready_out        = ready_q;
    assign uv_safe_out      = uvs_q;
    assign irq_out          = irq_q;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in || !ce_in);

    property p_hiz_until_vint;
        !pins_hiz_out |-> vint_on_out;
    endproperty
    a_hiz_until_vint: assert property (p_hiz_until_vint) else $error("pins driven without supply");
    property p_pin_order;
        (pin_release_out & ~{pin_release_out[NPINS-2:0], 1'b1}) == '0 && (|pin_release_out -> core_reset_n_out);
    endproperty
    a_pin_order: assert property (p_pin_order) else $error("pin release out of order");
    property p_greet_ready;
        greeting_out |-> !ready_out ##1 ready_out && &pin_release_out;
    endproperty
    a_greet_ready: assert property (p_greet_ready) else $error("greeting not followed by ready");
    property p_ok_store;
        ok_resp_out |-> store_req_out && $past(ready_out);
    endproperty
    a_ok_store: assert property (p_ok_store) else $error("ok without store");
    property p_off_clean;
        $fell(vint_on_out) |-> pins_hiz_out && pin_release_out == '0 && !core_reset_n_out;
    endproperty
    a_off_clean: assert property (p_off_clean) else $error("switch-off left pins or core up");
    property p_stay_off;
        (st_q == S_OFF && !pwr_evt) |=> st_q == S_OFF;
    endproperty
    a_stay_off: assert property (p_stay_off) else $error("left off without start-up event");
    property p_short_pulse;
        (pcnt_q < PWR_MIN_CYC - 16'h0001) |-> !pwr_evt;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("short power request accepted");
    property p_abrupt;
        (active && rst_evt && sy2_q[0] && !(ctrl_q[CTRL_TEMP] && temp_danger_in)) |=> !core_reset_n_out && vint_on_out;
    endproperty
    a_abrupt: assert property (p_abrupt) else $error("abrupt reboot missed");
    property p_vint_state;
        ##1 vint_on_out == !(st_q == S_OFF || st_q == S_SLEEP);
    endproperty
    a_vint_state: assert property (p_vint_state) else $error("supply does not match state");
    property p_temp;
        (active && ctrl_q[CTRL_TEMP] && temp_danger_in) |=> !vint_on_out ##1 istat_q[EV_TEMP];
    endproperty
    a_temp: assert property (p_temp) else $error("temperature shutdown missed");

    c_ready:  cover property (ev[EV_READY]);
    c_reboot: cover property (store_req_out ##[1:1000] detach_req_out ##[1:1000] !core_reset_n_out && vint_on_out);
    c_sleep:  cover property (st_q == S_SLEEP);
endmodule // mps_power_seq

// ### test/mps_host_model.sv
// host processor model driving the power request, abrupt reboot and fast-off pins
// assumes the bench calls its tasks from one process, clocked by the core clock
`timescale 1ns/100ps
module mps_host_model (
    input  wire logic clk_in,
    input  wire logic ready_in,
    output logic      power_request_n_out,
    output logic      reboot_n_out,
    output logic      fast_off_pin_out
);
    // power request and reboot pins idle high through pull-ups, fast-off pin idles low
    initial begin
        power_request_n_out = 1'b1;
        reboot_n_out        = 1'b1;
        fast_off_pin_out    = 1'b0;
    end

    // low pulse of a set length
    task automatic pulse_power(input int len);
        @(posedge clk_in) power_request_n_out <= 1'b0;
        repeat (len) @(posedge clk_in);
        power_request_n_out <= 1'b1;
    endtask

    task automatic set_reboot(input logic lvl);
        @(posedge clk_in) reboot_n_out <= lvl;
    endtask

    // host drives the input only once ready
    task automatic toggle_fast();
        if (ready_in === 1'b1) begin
            @(posedge clk_in) fast_off_pin_out <= ~fast_off_pin_out;
        end
    endtask
endmodule // mps_host_model

// ### test/tb.sv
// self-checking bench of the module power sequencer
// assumes shortened counts: power request 20 cycles, under-voltage margin 50 cycles
`timescale 1ns/100ps
module tb;
    import mps_pkg::*;
    logic core_clk_in = 1'b0, reset_n_in, ce;
    logic psel, penable, pwrite, store_done, detach_done, gasp, temp, sleep;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata_out;
    logic pready_out, pslverr_out, pwr_n, rb_n, fast_pin, vint_on_out, pins_hiz_out, core_reset_n_out;
    logic greeting_out, ok_resp_out, store_req_out, detach_req_out, ready_out, uv_safe_out, irq_out;
    logic [3:0] pin_release_out;
    logic [32:0] q[$];
    logic [8:0] seen;
    int n_fail = 0, n_checks = 0, seed = 7;

    always #5 core_clk_in = ~core_clk_in;

    mps_power_seq #(.PWR_MIN_CYC(16'd20), .UV_CYC(26'd50)) mps_power_seq_i (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ce_in(ce), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .power_request_n_in(pwr_n), .reboot_n_in(rb_n), .fast_off_pin_in(fast_pin),
        .store_done_in(store_done), .detach_done_in(detach_done), .last_gasp_sent_in(gasp),
        .temp_danger_in(temp), .sleep_req_in(sleep), .vint_on_out(vint_on_out),
        .pins_hiz_out(pins_hiz_out), .core_reset_n_out(core_reset_n_out),
        .pin_release_out(pin_release_out), .greeting_out(greeting_out), .ok_resp_out(ok_resp_out),
        .store_req_out(store_req_out), .detach_req_out(detach_req_out), .ready_out(ready_out),
        .uv_safe_out(uv_safe_out), .irq_out(irq_out));

    mps_host_model mps_host_model_i (.clk_in(core_clk_in), .ready_in(ready_out),
        .power_request_n_out(pwr_n), .reboot_n_out(rb_n), .fast_off_pin_out(fast_pin));

    task automatic wrap_up();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask

    // read results noted by the driver, compared as they come back
    always @(posedge core_clk_in) begin
        if (psel && penable && pready_out === 1'b1 && !pwrite) begin
            if (q.size() == 0) chk("unexpected read", 33'h0, {pslverr_out, prdata_out});
            else chk("apb read", q.pop_front(), {pslverr_out, prdata_out});
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        @(posedge core_clk_in);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
        if (!wr) q.push_back(e);
        @(posedge core_clk_in) penable <= 1'b1;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        psel <= 1'b0; penable <= 1'b0;
        if (n >= 50) begin
            chk("pready", 1, 0);
            wrap_up();
        end
    endtask

    function automatic logic [8:0] outs();
        return {uv_safe_out, irq_out, core_reset_n_out, ok_resp_out, greeting_out,
                detach_req_out, store_req_out, ready_out, vint_on_out};
    endfunction

    // bit 0 vint 1 ready 2 store 3 detach 4 greet 5 ok 6 core out of reset 7 irq 8 uv
    task automatic wt(input int s, input logic v);
        int n;
        logic [8:0] o;
        n = 0;
        do begin
            @(posedge core_clk_in);
            o = outs();
            seen |= o;
            n++;
        end while (o[s] !== v && n < 3000);
        if (n >= 3000) begin
            chk($sformatf("wait on %0d", s), v, ~v);
            wrap_up();
        end
    endtask

    task automatic done(input logic det);
        @(posedge core_clk_in);
        if (det) detach_done <= 1'b1;
        else store_done <= 1'b1;
        @(posedge core_clk_in);
        store_done <= 1'b0; detach_done <= 1'b0;
    endtask

    task automatic power_up(input logic greet);
        mps_host_model_i.pulse_power(30);
        wt(0, 1'b1);
        chk("hiz vs supply", 0, pins_hiz_out);
        chk("core held", 0, core_reset_n_out);
        wt(6, 1'b1);
        chk("pins after core", 0, pin_release_out);
        if (greet) wt(4, 1'b1);
        wt(1, 1'b1);
        chk("pins all out", 4'hf, pin_release_out);
    endtask

    initial begin
        reset_n_in  <= 1'b0;
        ce          <= 1'b1;
        psel        <= 1'b0;
        penable     <= 1'b0;
        pwrite      <= 1'b0;
        paddr       <= 8'h00;
        pwdata      <= 32'h0000_0000;
        store_done  <= 1'b0;
        detach_done <= 1'b0;
        gasp        <= 1'b0;
        temp        <= 1'b0;
        sleep       <= 1'b0;
        repeat (16) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        chk("supply off", 0, vint_on_out);
        chk("pins tri", 1, pins_hiz_out);
        apb(0, OFS_CTRL, 0, 0);
        apb(0, OFS_IMASK, 0, 0);
        apb(0, 8'h20, 0, 33'h1_0000_0000);
        apb(1, OFS_CTRL, 32'h0000_0001, 0);
        mps_host_model_i.pulse_power(5 + ($unsigned($random(seed)) % 10));
        repeat (40) @(posedge core_clk_in);
        chk("short pulse", 0, vint_on_out);
        power_up(1'b1);
        apb(0, OFS_STAT, 0, 33'h0_0000_0120);
        apb(0, OFS_ISTAT, 0, 33'h0_0000_0001);
        apb(1, OFS_IMASK, 32'h0000_0002, 0);
        @(posedge core_clk_in);
        chk("masked irq", 0, irq_out);
        apb(1, OFS_ISTAT, 32'h0000_000f, 0);
        apb(1, OFS_CMD, 32'h0000_0001, 0);
        wt(5, 1'b1);
        wt(2, 1'b1);
        done(0);
        wt(3, 1'b1);
        done(1);
        wt(0, 1'b0);
        chk("pins tri off", 1, pins_hiz_out);
        chk("pins reset", 0, pin_release_out);
        wt(7, 1'b1);
        apb(0, OFS_ISTAT, 0, 33'h0_0000_0002);
        apb(1, OFS_ISTAT, 32'h0000_0002, 0);
        wt(7, 1'b0);
        repeat (50) @(posedge core_clk_in);
        chk("stays off", 0, vint_on_out);
        @(posedge core_clk_in) ce <= 1'b0;
        mps_host_model_i.pulse_power(30);
        @(posedge core_clk_in) ce <= 1'b1;
        repeat (40) @(posedge core_clk_in);
        chk("frozen pulse", 0, vint_on_out);
        apb(1, OFS_CTRL, 32'h0000_000e, 0);
        for (int k = 0; k < 3; k++) begin
            power_up(1'b0);
            seen = '0;
            if (k == 0) apb(1, OFS_CMD, 32'h0000_000a, 0);
            else if (k == 1) mps_host_model_i.toggle_fast();
            else begin
                @(posedge core_clk_in) gasp <= 1'b1;
                @(posedge core_clk_in) gasp <= 1'b0;
            end
            wt(2, 1'b1);
            done(0);
            wt(0, 1'b0);
            chk("no detach", 0, seen[3]);
        end
        power_up(1'b0);
        apb(1, OFS_CMD, 32'h0000_0010, 0);
        wt(2, 1'b1);
        done(0);
        wt(3, 1'b1);
        done(1);
        wt(6, 1'b0);
        chk("reboot keeps supply", 1, vint_on_out);
        wt(1, 1'b1);
        seen = '0;
        mps_host_model_i.set_reboot(1'b0);
        wt(6, 1'b0);
        chk("abrupt keeps supply", 1, vint_on_out);
        chk("uv margin", 1, uv_safe_out);
        chk("abrupt no store", 0, seen[2]);
        mps_host_model_i.set_reboot(1'b1);
        wt(1, 1'b1);
        seen = '0;
        mps_host_model_i.set_reboot(1'b0);
        mps_host_model_i.pulse_power(30);
        wt(0, 1'b0);
        chk("emergency no store", 0, seen[2]);
        mps_host_model_i.set_reboot(1'b1);
        power_up(1'b0);
        @(posedge core_clk_in) temp <= 1'b1;
        wt(0, 1'b0);
        @(posedge core_clk_in) temp <= 1'b0;
        power_up(1'b0);
        @(posedge core_clk_in) sleep <= 1'b1;
        wt(0, 1'b0);
        @(posedge core_clk_in) sleep <= 1'b0;
        power_up(1'b0);
        wrap_up();
    end
endmodule // tb
